// ==== logic/dacr_device.sv ====
// Converter device end: two simultaneously sampled channels and their
// serial readout. The core runs on the internal conversion clock; the
// readout shifter runs on the serial clock that the host supplies.
//
// Functional notes
// - Two 16-bit channels sampled at one instant.
// - Conversion timed by internal clock only.
// - Inputs disconnected while converting.
// - Reconnect and re-acquire when conversion ends.
// - Converters take select, return start indication.
// - Results are two's complement.
// - Saturate at 8000 and 7FFF, zero mid.
// - Host keeps select high at least 15 ns.
// - Host keeps select low at least 15 ns.
// - Serial clock at most 32.768 MHz.
// - 14 ns from select low to capture.
// - 8 ns from last launch to select high.
// - Next bit per line on each launch edge.
// - Release data lines when select rises.
// - Select rising starts conversion; host spaces starts.
// - Acquire after reset and start indication.
// - MSB upper, MSB-1 lower, then zeros.
// - Select high length picks read latency; here a read returns the previous conversion only if select stays high until that conversion ends.
`default_nettype none

module dacr_device
    import dacr_pkg::*;
#(
    parameter int AIN_W = AIN_W_DEF
) (
    input  wire logic                    CORE_CLK,
    input  wire logic                    RESET,
    dacr_link_if.dev                     LINK,
    input  wire logic signed [AIN_W-1:0] AIN_A,
    input  wire logic signed [AIN_W-1:0] AIN_B,
    output logic             [ADC_W-1:0] RESULT_A,
    output logic             [ADC_W-1:0] RESULT_B,
    output logic                         CONVERTING,
    output logic                         START_IND
);

    // ----------------------------------------------------------------
    // Saturating coder
    // ----------------------------------------------------------------
    localparam logic signed [AIN_W-1:0] POS_LIM = AIN_W'(signed'(POS_FULL_CODE));
    localparam logic signed [AIN_W-1:0] NEG_LIM = -POS_LIM - AIN_W'(1);
    localparam logic [3:0] CONV_LAST = 4'(CONV_CYC - 1);

    // Inputs are differential levels in LSB units; out-of-range clips.
    function automatic logic [ADC_W-1:0] code_of(input logic signed [AIN_W-1:0] v);
        logic [ADC_W-1:0] c;
        c = v[ADC_W-1:0];
        if (v >= POS_LIM) begin
            c = POS_FULL_CODE;
        end else if (v <= NEG_LIM) begin
            c = NEG_FULL_CODE;
        end
        return c;
    endfunction

    // ----------------------------------------------------------------
    // Core domain: select synchroniser
    // ----------------------------------------------------------------
    logic       cs_meta_reg;
    logic       cs_sync_reg;
    logic       cs_prev_reg;
    wire  logic cs_rise;

    // The select pin is asynchronous to the conversion clock.
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
        end else begin
            cs_meta_reg <= LINK.cs_n;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
        end
    end

    // A rising select edge is the start of conversion.
    assign cs_rise = cs_sync_reg & ~cs_prev_reg;

    // ----------------------------------------------------------------
    // Core domain: acquire and convert sequencer
    // ----------------------------------------------------------------
    dacr_conv_t state_reg;
    dacr_conv_t state_next;
    logic [3:0] conv_cnt_reg;
    wire  logic conv_done;

    // The conversion length counts only internal clock cycles.
    assign conv_done = (state_reg == CONVERSION_STATE) && (conv_cnt_reg == CONV_LAST);

    // Next state of the sequencer.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ACQUISITION_STATE: begin
                if (cs_rise) begin
                    state_next = CONVERSION_STATE;
                end
            end
            CONVERSION_STATE: begin
                if (conv_done) begin
                    state_next = ACQUISITION_STATE;
                end
            end
        endcase
    end

    // Reset stands in for power-up and brings the core into acquisition.
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            state_reg <= ACQUISITION_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Conversion step counter, cleared at each start.
    always_ff @(posedge CORE_CLK) begin
        if (RESET || state_reg == ACQUISITION_STATE) begin
            conv_cnt_reg <= 4'h0;
        end else begin
            conv_cnt_reg <= conv_cnt_reg + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Core domain: sample hold and results
    // ----------------------------------------------------------------
    logic signed [AIN_W-1:0] hold_a_reg;
    logic signed [AIN_W-1:0] hold_b_reg;
    logic        [ADC_W-1:0] result_a_reg;
    logic        [ADC_W-1:0] result_b_reg;

    // Both holds track in acquisition and freeze together at the start
    // edge, so the two channels share one sampling instant.
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            hold_a_reg <= '0;
            hold_b_reg <= '0;
        end else if (state_reg == ACQUISITION_STATE && !cs_rise) begin
            hold_a_reg <= AIN_A;
            hold_b_reg <= AIN_B;
        end
    end

    // Each channel returns its result with the start indication.
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            result_a_reg <= MID_CODE;
            result_b_reg <= MID_CODE;
            START_IND    <= 1'b0;
            CONVERTING   <= 1'b0;
        end else begin
            START_IND    <= conv_done;
            CONVERTING   <= (state_next == CONVERSION_STATE);
            if (conv_done) begin
                result_a_reg <= code_of(hold_a_reg);
                result_b_reg <= code_of(hold_b_reg);
            end
        end
    end

    assign RESULT_A = result_a_reg;
    assign RESULT_B = result_b_reg;

    // ----------------------------------------------------------------
    // Link domain: bit step counter
    // ----------------------------------------------------------------
    logic [3:0] step_reg;
    wire  logic in_word;
    wire  logic [3:0] idx_up;
    wire  logic [3:0] idx_lo;

    // Select high clears the step without needing a serial clock edge,
    // because the host may stop the clock between frames.
    always_ff @(posedge LINK.sclk or posedge LINK.cs_n) begin
        if (LINK.cs_n) begin
            step_reg <= 4'h0;
        end else if (step_reg != 4'(BITS_PER_LINE)) begin
            step_reg <= step_reg + 4'h1;
        end
    end

    assign in_word = (step_reg < 4'(BITS_PER_LINE));
    assign idx_up  = 4'(ADC_W - 1) - {step_reg[2:0], 1'b0};
    assign idx_lo  = idx_up - 4'h1;

    // ----------------------------------------------------------------
    // Link domain: data lines
    // ----------------------------------------------------------------
    // The result words are read here without any sync stage: they
    // change only at the end of a conversion, which the host's cycle
    // spacing keeps clear of any frame. A frame overlapping a conversion
    // end may read a mixed word; that is the price of no buffer.
    assign LINK.sdo_out[LINE_UP_A] = in_word & result_a_reg[idx_up];
    assign LINK.sdo_out[LINE_LO_A] = in_word & result_a_reg[idx_lo];
    assign LINK.sdo_out[LINE_UP_B] = in_word & result_b_reg[idx_up];
    assign LINK.sdo_out[LINE_LO_B] = in_word & result_b_reg[idx_lo];

    // Lines drive only while select is low.
    assign LINK.sdo_oe_n = {LINE_N{LINK.cs_n}};

endmodule

`default_nettype wire

// ==== logic/dacr_host.sv ====
// Host end: frames a read with chip select, makes the serial clock by
// dividing its core clock, and assembles two 16-bit words.
// Assumes the device end is attached to the same link interface.
`default_nettype none

module dacr_host
    import dacr_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_DEF,
    parameter int GAP_CYC  = GAP_CYC_DEF
) (
    input  wire logic             CORE_CLK,
    input  wire logic             RESET,
    dacr_link_if.host             LINK,
    input  wire logic             START,
    output logic      [ADC_W-1:0] DATA_A,
    output logic      [ADC_W-1:0] DATA_B,
    output logic                  DATA_VALID,
    output logic                  BUSY
);

    localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);
    localparam logic [7:0] GAP_LAST  = 8'(GAP_CYC - 1);
    localparam logic [3:0] LAST_BIT  = 4'(BITS_PER_LINE - 1);

    // ----------------------------------------------------------------
    // Data line synchroniser
    // ----------------------------------------------------------------
    logic [LINE_N-1:0] sdo_meta_reg;
    logic [LINE_N-1:0] sdo_sync_reg;

    // Lines come from another part; two stages before any use.
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            sdo_meta_reg <= '0;
            sdo_sync_reg <= '0;
        end else begin
            sdo_meta_reg <= LINK.sdo_line;
            sdo_sync_reg <= sdo_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Frame sequencer
    // ----------------------------------------------------------------
    dacr_host_t state_reg;
    dacr_host_t state_next;
    logic [7:0] timer_reg;
    logic [3:0] bit_reg;
    wire  logic tick;
    wire  logic capture;

    assign tick    = (timer_reg == 8'h00);
    // Each half period outlasts the two sync stages, so the bit seen
    // here settled well after its launch edge.
    assign capture = tick && (state_reg == DACR_SETUP || state_reg == DACR_SCK_L);

    // Next state.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DACR_IDLE:  if (START) state_next = DACR_SETUP;
            DACR_SETUP,
            DACR_SCK_L: if (tick) begin
                state_next = (bit_reg == LAST_BIT) ? DACR_FIN : DACR_SCK_H;
            end
            DACR_SCK_H: if (tick) state_next = DACR_SCK_L;
            DACR_FIN:   if (tick) state_next = DACR_GAP;
            DACR_GAP:   if (tick) state_next = DACR_IDLE;
            default:    state_next = DACR_IDLE;
        endcase
    end

    // State, timer and bit index. Every phase lasts HALF_CYC cycles
    // except the gap, which spaces conversion starts.
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            state_reg <= DACR_IDLE;
            timer_reg <= 8'h00;
            bit_reg   <= 4'h0;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg) begin
                timer_reg <= (state_next == DACR_GAP) ? GAP_LAST : HALF_LAST;
            end else if (!tick) begin
                timer_reg <= timer_reg - 8'h01;
            end
            if (state_reg == DACR_IDLE) begin
                bit_reg <= 4'h0;
            end else if (capture) begin
                bit_reg <= bit_reg + 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Link pins and word assembly
    // ----------------------------------------------------------------
    logic              cs_n_reg;
    logic              sclk_reg;
    logic [ADC_W-1:0]  sh_a_reg;
    logic [ADC_W-1:0]  sh_b_reg;

    // Select low spans setup to finish; clock high only in its phase.
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            cs_n_reg <= 1'b1;
            sclk_reg <= 1'b0;
        end else begin
            cs_n_reg <= (state_next == DACR_IDLE) || (state_next == DACR_GAP);
            sclk_reg <= (state_next == DACR_SCK_H);
        end
    end

    assign LINK.cs_n = cs_n_reg;
    assign LINK.sclk = sclk_reg;

    // Upper line carries the even-from-top bit, lower the next one.
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            sh_a_reg <= '0;
            sh_b_reg <= '0;
        end else if (capture) begin
            sh_a_reg <= {sh_a_reg[ADC_W-3:0], sdo_sync_reg[LINE_UP_A],
                         sdo_sync_reg[LINE_LO_A]};
            sh_b_reg <= {sh_b_reg[ADC_W-3:0], sdo_sync_reg[LINE_UP_B],
                         sdo_sync_reg[LINE_LO_B]};
        end
    end

    // Words publish as select rises; that same edge starts the next
    // conversion, so each read returns the previous conversion.
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            DATA_A     <= '0;
            DATA_B     <= '0;
            DATA_VALID <= 1'b0;
            BUSY       <= 1'b0;
        end else begin
            DATA_VALID <= (state_reg == DACR_FIN) && tick;
            BUSY       <= (state_next != DACR_IDLE);
            if ((state_reg == DACR_FIN) && tick) begin
                DATA_A <= sh_a_reg;
                DATA_B <= sh_b_reg;
            end
        end
    end

endmodule

`default_nettype wire

// ==== logic/dacr_link_if.sv ====
// Serial link between the converter device and its host.
// The host drives chip select and the serial clock; the device drives
// four data lines with an active-low enable. Undriven lines read high.
`default_nettype none

interface dacr_link_if;
    import dacr_pkg::*;

    logic              cs_n;
    logic              sclk;
    logic [LINE_N-1:0] sdo_out;
    logic [LINE_N-1:0] sdo_oe_n;
    logic [LINE_N-1:0] sdo_line;

    // Resolved line level: a released line floats to a weak high.
    assign sdo_line = sdo_out | sdo_oe_n;

    modport dev (
        input  cs_n,
        input  sclk,
        output sdo_out,
        output sdo_oe_n
    );

    modport host (
        output cs_n,
        output sclk,
        input  sdo_line
    );

endinterface

`default_nettype wire

// ==== logic/dacr_pkg.sv ====
// Shared constants for the dual-channel converter readout link.
// Assumes a 20 MHz core clock on both ends and one link per device.
`default_nettype none

package dacr_pkg;

    // ----------------------------------------------------------------
    // Word format and output codes
    // ----------------------------------------------------------------
    localparam int              ADC_W         = 16;
    localparam int              AIN_W_DEF     = 18;
    localparam int              BITS_PER_LINE = ADC_W / 2;
    localparam logic [15:0]     NEG_FULL_CODE = 16'h8000; // negative_fullscale_code
    localparam logic [15:0]     MID_CODE      = 16'h0000; // midscale_code
    localparam logic [15:0]     POS_FULL_CODE = 16'h7FFF; // positive_fullscale_code

    // ----------------------------------------------------------------
    // Data line positions in the four-bit line vector
    // ----------------------------------------------------------------
    localparam int              LINE_LO_A     = 0;
    localparam int              LINE_UP_A     = 1;
    localparam int              LINE_LO_B     = 2;
    localparam int              LINE_UP_B     = 3;
    localparam int              LINE_N        = 4;

    // ----------------------------------------------------------------
    // Times in ns and their counts in core clock cycles
    // ----------------------------------------------------------------
    localparam int              CORE_PERIOD_NS = 50;
    localparam int              T_CONV_NS      = 422;
    localparam int              T_CYCLE_NS     = 488;
    localparam int              T_WH_CS_NS     = 15;
    localparam int              T_WL_CS_NS     = 15;
    localparam int              T_SU_CSCK_NS   = 14;
    localparam int              T_HT_CKCS_NS   = 8;
    localparam int              SCLK_MAX_KHZ   = 32768;
    // Longest time rounds down, least times round up.
    localparam int              CONV_CYC  = T_CONV_NS / CORE_PERIOD_NS;
    localparam int              CYCLE_CYC = (T_CYCLE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int              WH_CYC    = (T_WH_CS_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int              WL_CYC    = (T_WL_CS_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int              SU_CYC    = (T_SU_CSCK_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int              HT_CYC    = (T_HT_CKCS_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    // Sync stages plus edge detect seen by the device core.
    localparam int              SYNC_MARGIN   = 3;
    localparam int              SCLK_HALF_DEF = 3;
    localparam int              GAP_CYC_DEF   = CYCLE_CYC + SYNC_MARGIN;

    // ----------------------------------------------------------------
    // State types
    // ----------------------------------------------------------------
    typedef enum logic {
        ACQUISITION_STATE = 1'b0,
        CONVERSION_STATE  = 1'b1
    } dacr_conv_t;

    typedef enum logic [2:0] {
        DACR_IDLE  = 3'h0,
        DACR_SETUP = 3'h1,
        DACR_SCK_H = 3'h3,
        DACR_SCK_L = 3'h2,
        DACR_FIN   = 3'h6,
        DACR_GAP   = 3'h4
    } dacr_host_t;

endpackage

`default_nettype wire

// ==== tb/dacr_link_properties.sv ====
// Concurrent checks on the link between the host and device ends.
// Assumes the host core clock samples the link and default host timing.
`default_nettype none

module dacr_link_properties (
    input wire logic       CORE_CLK,
    input wire logic       RESET,
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic [3:0] sdo_out,
    input wire logic [3:0] sdo_oe_n,
    input wire logic [3:0] sdo_line
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // Helper logic
    // ----------------------------------------------------------------
    logic       sclk_d_reg;
    logic [3:0] rise_cnt_reg;
    wire        sclk_rise     = sclk & ~sclk_d_reg;
    wire  [3:0] rise_cnt_next = cs_n ? 4'h0 : rise_cnt_reg + {3'h0, sclk_rise};

    // Launch edges are counted per frame; select high clears the count.
    always_ff @(posedge CORE_CLK) begin
        sclk_d_reg   <= RESET ? 1'b0 : sclk;
        rise_cnt_reg <= RESET ? 4'h0 : rise_cnt_next;
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_release;
        cs_n |-> sdo_oe_n == 4'hF && sdo_line == 4'hF;
    endproperty
    a_release: assert property (p_release)
        else $error("data lines driven while deselected");
    property p_drive;
        !cs_n |-> sdo_oe_n == 4'h0 && sdo_line == sdo_out;
    endproperty
    a_drive: assert property (p_drive)
        else $error("data lines not driven in frame");
    property p_setup;
        $fell(cs_n) |-> !sclk [*3];
    endproperty
    a_setup: assert property (p_setup)
        else $error("serial clock too soon after select");
    property p_sclk_high;
        $rose(sclk) |-> sclk [*3] ##1 !sclk;
    endproperty
    a_sclk_high: assert property (p_sclk_high)
        else $error("serial clock high time wrong");
    property p_last_launch;
        $rose(cs_n) |-> !$past(sclk) && !$past(sclk, 3);
    endproperty
    a_last_launch: assert property (p_last_launch)
        else $error("select rose too soon after launch edge");
    property p_cs_high;
        $rose(cs_n) |-> cs_n [*8] ##1 cs_n [*2];
    endproperty
    a_cs_high: assert property (p_cs_high)
        else $error("select high time too short");
    property p_cs_low;
        $fell(cs_n) |-> !cs_n [*8] ##[39:43] $rose(cs_n);
    endproperty
    a_cs_low: assert property (p_cs_low)
        else $error("frame length wrong");
    property p_edges;
        $rose(cs_n) |-> rise_cnt_reg == 4'h7;
    endproperty
    a_edges: assert property (p_edges)
        else $error("launch edge count per frame wrong");

endmodule

`default_nettype wire

// ==== tb/tb_dual_adc_conversion_readout.sv ====
// Self-checking bench: host and device ends joined by one link.
// Assumes the package, interface, both ends and the checker compile first.
`default_nettype none

module tb_dual_adc_conversion_readout import dacr_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic                        core_clk = 1'b0;
    logic                        dev_clk  = 1'b0;
    logic                        reset, start;
    logic signed [AIN_W_DEF-1:0] ain_a, ain_b;
    logic        [ADC_W-1:0]     data_a, data_b, result_a, result_b, wire_a, wire_b, ind_res;
    logic                        data_valid, busy, converting, start_ind;
    int                          miscompares = 0, compares = 0, ind_cnt, conv_cnt;
    int                          valid_cnt, fall_cnt;

    dacr_link_if i_dacr_link_if ();
    wire [LINE_N-1:0] line = i_dacr_link_if.sdo_line;

    dacr_host i_dacr_host (.CORE_CLK(core_clk), .RESET(reset), .LINK(i_dacr_link_if),
        .START(start), .DATA_A(data_a), .DATA_B(data_b), .DATA_VALID(data_valid), .BUSY(busy));
    dacr_device i_dacr_device (.CORE_CLK(dev_clk), .RESET(reset), .LINK(i_dacr_link_if),
        .AIN_A(ain_a), .AIN_B(ain_b), .RESULT_A(result_a), .RESULT_B(result_b),
        .CONVERTING(converting), .START_IND(start_ind));
    dacr_link_properties i_dacr_link_properties (.CORE_CLK(core_clk), .RESET(reset),
        .cs_n(i_dacr_link_if.cs_n), .sclk(i_dacr_link_if.sclk),
        .sdo_out(i_dacr_link_if.sdo_out), .sdo_oe_n(i_dacr_link_if.sdo_oe_n),
        .sdo_line(i_dacr_link_if.sdo_line));

    // The device oscillator drifts against the host clock, so phases vary.
    always #25 core_clk = ~core_clk;
    always #25.3 dev_clk = ~dev_clk;

    // ----------------------------------------------------------------
    // Monitors
    // ----------------------------------------------------------------
    // Conversion activity counted in the device clock domain.
    always @(posedge dev_clk) begin
        if (start_ind === 1'b1) begin
            ind_cnt++;
            ind_res = result_a;
        end
        if (converting === 1'b1) conv_cnt++;
    end
    always @(posedge core_clk) begin
        if (data_valid === 1'b1) valid_cnt++;
    end
    // The words are rebuilt from the wire itself, independent of the host.
    always @(negedge i_dacr_link_if.cs_n) begin
        #1;
        fall_cnt++;
        wire_a = {14'h0000, line[LINE_UP_A], line[LINE_LO_A]};
        wire_b = {14'h0000, line[LINE_UP_B], line[LINE_LO_B]};
    end
    always @(posedge i_dacr_link_if.sclk) begin
        #1;
        if (i_dacr_link_if.cs_n === 1'b0) begin
            wire_a = {wire_a[13:0], line[LINE_UP_A], line[LINE_LO_A]};
            wire_b = {wire_b[13:0], line[LINE_UP_B], line[LINE_LO_B]};
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [15:0] clip(input logic signed [AIN_W_DEF-1:0] v);
        if (v > 32767) return POS_FULL_CODE;
        if (v < -32768) return NEG_FULL_CODE;
        return v[15:0];
    endfunction

    // One read frame; the wait is bounded so a stuck host is reported.
    task automatic frame();
        int n;
        @(posedge core_clk) start <= 1'b1;
        @(posedge core_clk) start <= 1'b0;
        n = 0;
        while (data_valid !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        while (busy !== 1'b0 && n < 400) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check("frame ends", 16'(n < 400), 16'h0001);
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic results();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        check("busy", busy, 1'b0);
        check("converting", converting, 1'b0);
        check("result a", result_a, MID_CODE);
        check("idle lines", line, 4'hF);
        $display("test reset done");
    endtask

    // Each frame converts the new inputs and reads the previous result.
    task automatic t_codes();
        int          vals [9] = '{-131072, -32769, -32768, -1, 0, 1, 32767, 32768, 131071};
        logic [15:0] prev_a, prev_b;
        prev_a = 16'h0000;
        prev_b = 16'h0000;
        for (int i = 0; i < 9; i++) begin
            @(posedge core_clk);
            ain_a <= AIN_W_DEF'(vals[i]);
            ain_b <= AIN_W_DEF'(~vals[i]);
            frame();
            check("data a", data_a, prev_a);
            check("data b", data_b, prev_b);
            check("wire a", wire_a, prev_a);
            check("wire b", wire_b, prev_b);
            check("result a", result_a, clip(ain_a));
            check("result b", result_b, clip(ain_b));
            prev_a = clip(ain_a);
            prev_b = clip(ain_b);
        end
        $display("test codes done");
    endtask

    // Inputs that move during conversion must not reach the result.
    task automatic t_hold();
        @(posedge core_clk);
        ain_a    <= 18'h004D2;
        ain_b    <= 18'h3FB2E;
        ind_cnt  = 0;
        conv_cnt = 0;
        fork
            frame();
            begin
                @(posedge core_clk iff converting === 1'b1);
                ain_a <= 18'h1FFFF;
                ain_b <= 18'h20000;
            end
        join
        check("held a", result_a, 16'h04D2);
        check("held b", result_b, 16'hFB2E);
        check("start count", 16'(ind_cnt), 16'h0001);
        check("convert cycles", 16'(conv_cnt), 16'(CONV_CYC));
        check("result at start", ind_res, 16'h04D2);
        check("back to acquire", converting, 1'b0);
        $display("test hold done");
    endtask

    // A request during a frame is dropped; the frame reads the last result.
    task automatic t_refused();
        valid_cnt = 0;
        fall_cnt  = 0;
        fork
            frame();
            begin
                repeat (10) @(posedge core_clk);
                start <= 1'b1;
                @(posedge core_clk);
                start <= 1'b0;
            end
        join
        repeat (20) @(posedge core_clk);
        #1;
        check("valid count", 16'(valid_cnt), 16'h0001);
        check("frame count", 16'(fall_cnt), 16'h0001);
        check("latency one", data_a, 16'h04D2);
        check("released", line, 4'hF);
        $display("test refused done");
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        reset = 1'b1;
        start = 1'b0;
        ain_a = '0;
        ain_b = '0;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1;
        t_reset();
        t_codes();
        t_hold();
        t_refused();
        results();
    end

    // The tests need about 750 cycles; over six times that means a hang.
    initial begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        results();
    end

endmodule

`default_nettype wire
